/* rtl/sutwu_consts.vh */
`ifndef SUTWU_CONSTS_VH
`define SUTWU_CONSTS_VH
// Register byte addresses (word aligned, index times four)
`define SUTWU_IDX_CTRL       4'hD
`define SUTWU_ADDR_CTRL      6'h34
`define SUTWU_ADDR_STATUS    6'h38
`define SUTWU_ADDR_DATA      6'h3C
`define SUTWU_ADDR_PINS      6'h30
// Control field positions
`define SUTWU_CTRL_SIE       7
`define SUTWU_CTRL_OIE       6
`define SUTWU_CTRL_WM_HI     5
`define SUTWU_CTRL_WM_LO     4
`define SUTWU_CTRL_CS_HI     3
`define SUTWU_CTRL_CS_LO     2
`define SUTWU_CTRL_STB       1
`define SUTWU_CTRL_TGL       0
// Status field positions
`define SUTWU_STAT_SIF       7
`define SUTWU_STAT_OIF       6
`define SUTWU_STAT_CNT_HI    3
// Pin register field positions
`define SUTWU_PIN_SDA_OUT    0
`define SUTWU_PIN_SCL_OUT    1
`define SUTWU_PIN_SDA_DIR    2
`define SUTWU_PIN_SCL_DIR    3
// Reset values
`define SUTWU_CTRL_RST       8'h00
`define SUTWU_PINS_RST       4'h3
// Wire modes
`define SUTWU_WM_OFF         2'h0
`define SUTWU_WM_THREE       2'h1
`define SUTWU_WM_TWO         2'h2
// Start detector SDA delay: 40 ns least, 100 ns most, at 20 ns clock
`define SUTWU_SDA_DLY_NS     40
`define SUTWU_CLK_NS         20
`define SUTWU_SDA_DLY_CYC    ((`SUTWU_SDA_DLY_NS + `SUTWU_CLK_NS - 1) / `SUTWU_CLK_NS)
`endif

/* rtl/sutwu_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "sutwu_consts.vh"

// Overview of operation
// - Two-wire protocol, no slew limit or filter
// - Master makes clock; slave uses stretching
// - Start detector sets start-seen flag
// - Hold SCL low after start falling edge
// - Shift SDA in on rising SCL
// - Overflow after eight bits forces SCL low
// - Unaddressed slave releases SCL, awaits start
// - Ack by SDA low; counter loaded 14
// - Direction bit decides who drives SDA
// - Bytes continue until stop or start
// - Withhold acknowledge when unable to accept
// - Delayed SDA; detector only two-wire
// - Start detector needs no clock edge logic
// - Serial clock at most system clock/2
// - External clock counts both edges
// - Counter at F overflows next edge
// - Software strobe advances counter, clock sources 0 and 2
// - Control register bits, reset zero
// - Start irq taken when enabled
// - Overflow irq taken when enabled
// - Wire mode field selects operation
// - SDA low when MSB or latch zero
// - Clearing start flag releases SCL
module sutwu_top (
	// Clock and reset
	input  wire        clk_sys,
	input  wire        rstn,
	// Avalon-MM slave
	input  wire [5:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	// Global interrupt enable and interrupt request lines
	input  wire        global_irq_en,
	output reg         start_irq,
	output reg         overflow_irq,
	// Timer compare match clock source
	input  wire        timer_match,
	// Two-wire pins, open drain
	input  wire        sda_in,
	output reg         sda_out,
	output reg         sda_oe,
	input  wire        scl_in,
	output reg         scl_out,
	output reg         scl_oe
);

	reg  [7:0] ctrl_q;
	reg  [7:0] shift_data_reg_q;
	reg  [3:0] cnt_q;
	reg        start_seen_flag_q;
	reg        count_overflow_flag_q;
	reg        start_hold_q;
	reg        ovf_hold_q;
	reg  [3:0] pins_q;
	reg        acc_done_q;
	reg  [1:0] sda_sync_q;
	reg  [1:0] scl_sync_q;
	reg        scl_prev_q;
	reg  [`SUTWU_SDA_DLY_CYC:0] sda_dly_q;
	reg        start_armed_q;
	reg        timer_prev_q;

	wire [1:0] wire_mode = ctrl_q[`SUTWU_CTRL_WM_HI:`SUTWU_CTRL_WM_LO];
	wire [1:0] clk_src   = ctrl_q[`SUTWU_CTRL_CS_HI:`SUTWU_CTRL_CS_LO];
	wire       two_wire  = (wire_mode == `SUTWU_WM_TWO);
	wire       outs_on   = (wire_mode != `SUTWU_WM_OFF);
	wire       scl_s     = scl_sync_q[1];
	wire       sda_s     = sda_sync_q[1];
	// Edges need one sample per level, hence clk/2 limit
	wire       scl_rise  = scl_s & ~scl_prev_q;
	wire       scl_fall  = ~scl_s & scl_prev_q;
	wire       sda_old   = sda_dly_q[`SUTWU_SDA_DLY_CYC];

	// Bus access decode; answer comes one cycle after the request.
	// Writes land only in the answer cycle, the edge at which the
	// master sees waitrequest low, so no write lands twice or early.
	wire       req     = (avs_read | avs_write) & ~acc_done_q;
	wire       wr      = avs_write & acc_done_q & ~avs_waitrequest;
	wire       wr_ctrl = wr & (avs_address == `SUTWU_ADDR_CTRL) &
		avs_byteenable[0];
	wire       wr_stat = wr & (avs_address == `SUTWU_ADDR_STATUS) &
		avs_byteenable[0];
	wire       wr_data = wr & (avs_address == `SUTWU_ADDR_DATA) &
		avs_byteenable[0];
	wire       wr_pins = wr & (avs_address == `SUTWU_ADDR_PINS) &
		avs_byteenable[0];

	// Software strobe and toggle, write-only bits
	wire       sw_strobe = wr_ctrl & avs_writedata[`SUTWU_CTRL_STB];
	wire       sw_toggle = wr_ctrl & avs_writedata[`SUTWU_CTRL_TGL];

	// Counter clock selection: both edges for external source
	reg        cnt_tick;
	reg        shift_tick;
	always @* begin
		cnt_tick   = 1'b0;
		shift_tick = 1'b0;
		case (clk_src)
			2'h0: begin
				cnt_tick   = sw_strobe;
				shift_tick = sw_strobe;
			end
			2'h1: begin
				cnt_tick   = timer_match & ~timer_prev_q;
				shift_tick = cnt_tick;
			end
			default: begin
				// Both edges advance counter
				cnt_tick   = scl_rise | scl_fall |
					(sw_strobe & ~clk_src[0]);
				// Sample on rising edge for positive mode
				shift_tick = clk_src[0] ? scl_fall : scl_rise;
			end
		endcase
	end

	// Overflow when counter wraps from F
	wire       cnt_wrap = cnt_tick & (cnt_q == 4'hF);

	// Input synchronisers and edge history
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sda_sync_q   <= 2'h3;
			scl_sync_q   <= 2'h3;
			scl_prev_q   <= 1'b1;
			sda_dly_q    <= {(`SUTWU_SDA_DLY_CYC + 1){1'b1}};
			timer_prev_q <= 1'b0;
		end else begin
			sda_sync_q   <= {sda_sync_q[0], sda_in};
			scl_sync_q   <= {scl_sync_q[0], scl_in};
			scl_prev_q   <= scl_s;
			// Delayed SDA so SCL is seen settled
			sda_dly_q    <= {sda_dly_q[`SUTWU_SDA_DLY_CYC - 1:0], sda_s};
			timer_prev_q <= timer_match;
		end
	end

	// Start condition: SDA falls while SCL high, two-wire only
	wire start_det = two_wire & scl_s & sda_old & ~sda_s;

	// Control, flags, holds, counter and data
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctrl_q                <= `SUTWU_CTRL_RST;
			shift_data_reg_q      <= 8'hFF;
			cnt_q                 <= 4'h0;
			start_seen_flag_q     <= 1'b0;
			count_overflow_flag_q <= 1'b0;
			start_hold_q          <= 1'b0;
			start_armed_q         <= 1'b0;
			ovf_hold_q            <= 1'b0;
			pins_q                <= `SUTWU_PINS_RST;
		end else begin
			// Strobe and toggle bits never stored
			if (wr_ctrl) begin
				ctrl_q <= {avs_writedata[7:2], 2'h0};
			end
			if (wr_pins) begin
				pins_q <= avs_writedata[3:0];
			end else if (sw_toggle) begin
				pins_q[`SUTWU_PIN_SCL_OUT] <= ~pins_q[`SUTWU_PIN_SCL_OUT];
			end
			// Shift in sampled SDA on selected edge
			if (wr_data) begin
				shift_data_reg_q <= avs_writedata[7:0];
			end else if (shift_tick) begin
				shift_data_reg_q <= {shift_data_reg_q[6:0], sda_s};
			end
			// Software load wins; 14 loaded for acknowledge
			if (wr_stat) begin
				cnt_q <= avs_writedata[`SUTWU_STAT_CNT_HI:0];
			end else if (cnt_tick) begin
				cnt_q <= cnt_q + 4'h1;
			end
			// Start flag: set wins over clear-by-one
			if (start_det) begin
				start_seen_flag_q <= 1'b1;
			end else if (wr_stat & avs_writedata[`SUTWU_STAT_SIF]) begin
				start_seen_flag_q <= 1'b0;
			end
			// Overflow flag, set wins over clear
			if (cnt_wrap) begin
				count_overflow_flag_q <= 1'b1;
			end else if (wr_stat & avs_writedata[`SUTWU_STAT_OIF]) begin
				count_overflow_flag_q <= 1'b0;
			end
			// Arm on start, hold SCL at next falling edge
			if (start_det) begin
				start_armed_q <= 1'b1;
			end else if (wr_stat & avs_writedata[`SUTWU_STAT_SIF]) begin
				start_armed_q <= 1'b0;
			end else if (start_armed_q & scl_fall) begin
				start_armed_q <= 1'b0;
			end
			if (start_armed_q & scl_fall & two_wire) begin
				start_hold_q <= 1'b1;
			end else if (wr_stat & avs_writedata[`SUTWU_STAT_SIF] &
				~start_det) begin
				start_hold_q <= 1'b0;
			end else if (!two_wire) begin
				start_hold_q <= 1'b0;
			end
			// Overflow hold in two-wire slave; released by clearing
			// overflow flag, which lets software ack or drop
			if (cnt_wrap & two_wire) begin
				ovf_hold_q <= 1'b1;
			end else if (wr_stat & avs_writedata[`SUTWU_STAT_OIF]) begin
				ovf_hold_q <= 1'b0;
			end else if (!two_wire) begin
				ovf_hold_q <= 1'b0;
			end
		end
	end

	// Open-drain pin drive; enables high while pulling low
	// SDA driven by whoever the direction bit selects
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sda_out <= 1'b0;
			sda_oe  <= 1'b0;
			scl_out <= 1'b0;
			scl_oe  <= 1'b0;
		end else begin
			sda_out <= 1'b0;
			scl_out <= 1'b0;
			// Pull low if data MSB or latch is zero
			sda_oe  <= outs_on & pins_q[`SUTWU_PIN_SDA_DIR] &
				(~shift_data_reg_q[7] | ~pins_q[`SUTWU_PIN_SDA_OUT]);
			// Clock stretching only in slave two-wire use
			scl_oe  <= outs_on & pins_q[`SUTWU_PIN_SCL_DIR] &
				(~pins_q[`SUTWU_PIN_SCL_OUT] |
				(two_wire & (start_hold_q | ovf_hold_q)));
		end
	end

	// Interrupt lines gated by enable and global enable
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			start_irq    <= 1'b0;
			overflow_irq <= 1'b0;
		end else begin
			start_irq    <= start_seen_flag_q & global_irq_en &
				ctrl_q[`SUTWU_CTRL_SIE];
			overflow_irq <= count_overflow_flag_q & global_irq_en &
				ctrl_q[`SUTWU_CTRL_OIE];
		end
	end

	// Avalon slave: waitrequest high until one cycle answer
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			acc_done_q      <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
		end else begin
			acc_done_q      <= req;
			avs_waitrequest <= ~req;
			if (req & avs_read) begin
				case (avs_address)
					`SUTWU_ADDR_CTRL:
						avs_readdata <= {24'h000000, ctrl_q};
					`SUTWU_ADDR_STATUS:
						avs_readdata <= {24'h000000, start_seen_flag_q,
							count_overflow_flag_q, 2'h0, cnt_q};
					`SUTWU_ADDR_DATA:
						avs_readdata <= {24'h000000, shift_data_reg_q};
					`SUTWU_ADDR_PINS:
						avs_readdata <= {26'h0000000, scl_s, sda_s, pins_q};
					default:
						avs_readdata <= 32'h00000000;
				endcase
			end
		end
	end

endmodule // sutwu_top
`default_nettype wire

/* tb/sutwu_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module sutwu_checker (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        rstn,
	// Register bus
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// Interrupts
	input wire logic        global_irq_en,
	input wire logic        start_irq,
	input wire logic        overflow_irq,
	// Pins
	input wire logic        sda_in,
	input wire logic        sda_out,
	input wire logic        scl_in,
	input wire logic        scl_out,
	input wire logic        scl_oe
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	logic [3:0] wr_age_q;
	// Age of the last write; saturates so old writes never look recent
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn) wr_age_q <= 4'hF;
		else if (avs_write && !avs_waitrequest) wr_age_q <= 4'h0;
		else if (wr_age_q != 4'hF) wr_age_q <= wr_age_q + 4'h1;
	a_wait_pulse: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	a_req_answer: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
		else $error("bus request not answered next cycle");
	a_rdata_upper: assert property (avs_readdata[31:8] == 24'h000000)
		else $error("upper read data not zero");
	a_open_drain: assert property (!sda_out && !scl_out)
		else $error("pin driven high");
	a_hold_low: assert property ($rose(scl_oe) |-> !scl_in)
		else $error("clock hold began with line high");
	a_hold_release: assert property ($fell(scl_oe) |-> wr_age_q < 4'h4)
		else $error("clock released without software write");
	a_start_gate: assert property (start_irq |-> $past(global_irq_en))
		else $error("start irq without global enable");
	a_ovf_gate: assert property (overflow_irq |-> $past(global_irq_en))
		else $error("overflow irq without global enable");
	a_start_sda: assert property ($rose(start_irq) |-> !sda_in)
		else $error("start irq while data line high");
	c_start: cover property ($rose(start_irq));
	c_ovf: cover property ($rose(overflow_irq));
	c_hold: cover property ($rose(scl_oe));
endmodule // sutwu_checker
bind sutwu_top sutwu_checker chk (.clk_sys(clk_sys), .rstn(rstn),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .global_irq_en(global_irq_en),
	.start_irq(start_irq), .overflow_irq(overflow_irq), .sda_in(sda_in),
	.sda_out(sda_out), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe));
`default_nettype wire

/* tb/sutwu_master.sv */
`timescale 1ns/1ps
`default_nettype none
module sutwu_master (
	// Clock and bus lines
	input  wire logic clk_sys,
	input  wire logic scl_line,
	input  wire logic sda_line,
	// Open-drain drives, low pulls the line
	output var  logic scl_o,
	output var  logic sda_o
);
	// Lines released at start
	initial begin
		scl_o = 1'h1;
		sda_o = 1'h1;
	end
	// 80 ns step; a bit takes three plus at least one wait cycle (260 ns), well under the clk/2 limit
	task automatic half();
		repeat (4) @(posedge clk_sys);
	endtask
	// Data falls while clock high, then clock falls
	task automatic start_c();
		sda_o <= 1'h0;
		half();
		half();
		scl_o <= 1'h0;
		half();
	endtask
	// One bit; waits while the slave stretches, bounded
	task automatic bit_io(input logic b, output logic r);
		int n;
		sda_o <= b;
		half();
		scl_o <= 1'h1;
		n = 0;
		while (scl_line !== 1'h1 && n < 2000) begin
			@(posedge clk_sys);
			n++;
		end
		half();
		r = sda_line;
		scl_o <= 1'h0;
		half();
	endtask
endmodule // sutwu_master
`default_nettype wire

/* tb/sutwu_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module sutwu_top_bench;
	logic        clk_sys;
	logic        rstn;
	logic [5:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic        global_irq_en;
	wire  [31:0] avs_readdata;
	wire         avs_waitrequest, start_irq, overflow_irq;
	wire         sda_out, sda_oe, scl_out, scl_oe, m_scl, m_sda;
	wire         scl_line, sda_line;
	int          miscompares, checks, cycles;
	logic [7:0]  q;
	// Pulled-up wired-AND lines
	assign scl_line = m_scl & ~scl_oe;
	assign sda_line = m_sda & ~sda_oe;
	sutwu_top uut (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.global_irq_en(global_irq_en), .start_irq(start_irq),
		.overflow_irq(overflow_irq), .timer_match(1'h0), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .scl_in(scl_line),
		.scl_out(scl_out), .scl_oe(scl_oe));
	sutwu_master m (.clk_sys(clk_sys), .scl_line(scl_line),
		.sda_line(sda_line), .scl_o(m_scl), .sda_o(m_sda));
	// Clock, and a cycle ceiling against hangs
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 6000) begin
			miscompares++;
			end_sim();
		end
	end
	task automatic end_sim();
		if (miscompares == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	// Held until waitrequest is sampled low, then one idle edge
	task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_write <= w;
		avs_read <= !w;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'h0) @(posedge clk_sys);
		q = avs_readdata[7:0];
		avs_write <= 1'h0;
		avs_read <= 1'h0;
		@(posedge clk_sys);
	endtask
	task automatic settle();
		repeat (3) @(posedge clk_sys);
	endtask
	task automatic t_regs();
		bus(0, 6'h34, 8'h00);
		cmp("ctrl reset", 8'h00, q);
		bus(0, 6'h00, 8'h00);
		cmp("unmapped", 8'h00, q);
		bus(1, 6'h34, 8'hCE);
		bus(0, 6'h34, 8'h00);
		cmp("ctrl rw", 8'hCC, q);
	endtask
	task automatic t_soft();
		bus(1, 6'h34, 8'h40);
		bus(1, 6'h38, 8'h0F);
		bus(1, 6'h34, 8'h42);
		bus(0, 6'h38, 8'h00);
		cmp("strobe ovf", 8'h40, q);
		cmp("ovf irq", 8'h01, overflow_irq);
		global_irq_en <= 1'h0;
		settle();
		cmp("ovf masked", 8'h00, overflow_irq);
		global_irq_en <= 1'h1;
		bus(1, 6'h38, 8'h40);
		bus(0, 6'h38, 8'h00);
		cmp("ovf clear", 8'h00, q);
	endtask
	task automatic t_link();
		logic [7:0] b;
		logic r;
		b = 8'hA5;
		bus(1, 6'h30, 8'h0F);
		bus(1, 6'h34, 8'hA8);
		m.start_c();
		bus(0, 6'h38, 8'h00);
		cmp("start flag", 8'h80, q & 8'hC0);
		cmp("start irq", 8'h01, start_irq);
		cmp("start hold", 8'h01, scl_oe);
		bus(1, 6'h38, 8'h80);
		settle();
		cmp("start release", 8'h00, scl_oe);
		for (int i = 7; i >= 0; i--) m.bit_io(b[i], r);
		bus(0, 6'h38, 8'h00);
		cmp("byte ovf", 8'h40, q);
		cmp("byte hold", 8'h01, scl_oe);
		bus(0, 6'h3C, 8'h00);
		cmp("byte data", 8'hA5, q);
		bus(1, 6'h3C, 8'h00);
		bus(1, 6'h38, 8'h4E);
		settle();
		cmp("ack drive", 8'h01, sda_oe);
		cmp("ack release", 8'h00, scl_oe);
		m.bit_io(1'h1, r);
		settle();
		cmp("ack seen", 8'h00, r);
		cmp("ack hold", 8'h01, scl_oe);
	endtask
	// Reset for four cycles, then the scenarios
	initial begin
		clk_sys = 1'h0;
		rstn = 1'h0;
		avs_address = 6'h00;
		avs_read = 1'h0;
		avs_write = 1'h0;
		avs_writedata = 32'h00000000;
		global_irq_en = 1'h1;
		repeat (4) @(posedge clk_sys);
		rstn <= 1'h1;
		@(posedge clk_sys);
		t_regs();
		t_soft();
		t_link();
		end_sim();
	end
endmodule // sutwu_top_bench
`default_nettype wire
